// ### atst_pkg.sv
// Package with register map, field layouts, reset values and timing constants of the acquisition trigger block.
package atst_pkg;

  // Clock rate and microsecond tick.
  localparam int unsigned CLK_FREQ_HZ = 10000000;
  localparam int unsigned TICK_TIME_NS = 1000;
  localparam int unsigned TICK_CYCLES = (TICK_TIME_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;

  // Fixed busy times in microseconds, defaults of top-level parameters.
  localparam logic [31:0] INIT_BUSY_US = 32'h0000_00da;
  localparam logic [31:0] FINAL_BUSY_US = 32'h0000_00da;
  // Cycles of the data transfer stand-in after final busy.
  localparam logic [31:0] XFER_CYCLES = 32'h0000_0010;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_ACQ_DLY = 8'h08;
  localparam logic [7:0] OFS_INTEG = 8'h0c;
  localparam logic [7:0] OFS_SS_DLY = 8'h10;
  localparam logic [7:0] OFS_SS_WID = 8'h14;
  localparam logic [7:0] OFS_CS_PER = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // Control field positions.
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_SS_EN_BIT = 2;
  localparam int unsigned CTRL_CS_EN_BIT = 3;
  localparam int unsigned CMD_TRIG_BIT = 0;

  // Reset values.
  localparam logic [31:0] RST_INTEG = 32'h0000_0064;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    ATST_MODE_SW = 2'b00,
    ATST_MODE_EDGE = 2'b01,
    ATST_MODE_LEVEL = 2'b10
  } atst_mode_type;

  typedef enum logic [2:0] {
    ATST_IDLE = 3'b000,
    ATST_DELAY = 3'b001,
    ATST_INTEG = 3'b010,
    ATST_BUSY = 3'b011,
    ATST_XFER = 3'b100
  } atst_state_type;

  // Programmed timing, all in microseconds.
  typedef struct packed {
    logic [31:0] acq_dly;
    logic [31:0] integ;
    logic [31:0] ss_dly;
    logic [31:0] ss_wid;
    logic [31:0] cs_per;
  } atst_timing_type;

  // Count of microseconds at or beyond a programmed mark.
  function automatic logic reached(input logic [31:0] cnt, input logic [31:0] mark);
    return cnt >= mark;
  endfunction

endpackage

// ### atst_sync.sv
// Three-stage synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
module atst_sync
  import atst_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic async_i,
  output logic sync_o
);

  logic [2:0] stage;

  // The first stage feeds only the second, to keep metastability out of the decision.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stage <= 3'h0;
      sync_o <= 1'b0;
    end else begin
      stage <= {stage[1:0], async_i};
      if (stage[2] == stage[1]) begin
        sync_o <= stage[2];
      end
    end
  end

endmodule

// ### atst_tick.sv
// Free-running prescaler that gives one pulse per microsecond.
`timescale 1ns/1ps
module atst_tick
  import atst_pkg::*;
#(
  parameter int unsigned DIV = TICK_CYCLES
)
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic restart_i,
  output logic tick_o
);

  logic [7:0] cnt;

  // A restart aligns the microsecond grid to the trigger event.
  always_ff @(posedge clk_i) begin
    if (srst_i || restart_i) begin
      cnt <= 8'h00;
      tick_o <= 1'b0;
    end else if (cnt == 8'(DIV - 1)) begin
      cnt <= 8'h00;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
      tick_o <= 1'b0;
    end
  end

endmodule

// ### atst_top.sv
// Acquisition trigger sequencer with single and continuous strobe generation behind an APB slave.
//
// Summary of operation
// - Single strobe is one active-high pulse per cycle.
// - Single strobe rises after its delay from trigger.
// - Single strobe stays high for its width.
// - Single strobe forced low at integration end.
// - Single strobe timed from trigger, not acquisition delay.
// - Each strobe has its own enable.
// - Continuous strobe: 50% duty, programmed period, integration only.
// - Continuous strobe starts with integration.
// - Software and edge modes: only complete periods.
// - A period needs integration at least as long as period.
// - Level mode: continuous strobe cut at integration end.
// - Cycle runs delay, integration, final busy.
// - Delay equals acquisition delay plus initial busy.
// - Acquisition delay never changes integration length outside level mode.
// - Three trigger modes chosen by mode field.
// - Reset selects software triggering.
// - Software command creates the trigger event.
// - Edge mode starts on external rising edge.
// - Level mode integrates while input held high.
// - Final busy, data transfer, then ready again.
// - Timing values count whole microseconds.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module atst_top
  import atst_pkg::*;
#(
  parameter logic [31:0] INIT_BUSY = INIT_BUSY_US,
  parameter logic [31:0] FINAL_BUSY = FINAL_BUSY_US
)
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ext_trig_i,
  output logic single_strobe_o,
  output logic cont_strobe_o,
  output logic busy_o,
  output logic integrating_o
);

  atst_mode_type mode;
  logic ss_en;
  logic cs_en;
  atst_timing_type tim;
  atst_state_type state;
  atst_state_type next_state;
  logic [31:0] cyc_us;
  logic [31:0] ph_us;
  logic [31:0] cs_us;
  logic [31:0] xfer_cnt;
  logic ss_done;
  logic ext_sync;
  logic ext_prev;
  logic tick;
  logic sw_trig;
  logic [31:0] trig_count;

  // APB decode; the slave answers in the access cycle with no wait state.
  wire apb_access = psel_i && penable_i;
  wire apb_wr = apb_access && pwrite_i;
  wire addr_ok = (paddr_i[1:0] == 2'b00) && (paddr_i <= OFS_STATUS);
  wire wr_ctrl = apb_wr && (paddr_i == OFS_CTRL);
  wire wr_cmd = apb_wr && (paddr_i == OFS_CMD) && pstrb_i[0] && pwdata_i[CMD_TRIG_BIT];

  // Byte-lane merge for timing register writes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Read data selection.
  logic [31:0] rd_mux;
  assign rd_mux = (paddr_i == OFS_CTRL) ? {28'h0000000, cs_en, ss_en, mode} :
                  (paddr_i == OFS_ACQ_DLY) ? tim.acq_dly :
                  (paddr_i == OFS_INTEG) ? tim.integ :
                  (paddr_i == OFS_SS_DLY) ? tim.ss_dly :
                  (paddr_i == OFS_SS_WID) ? tim.ss_wid :
                  (paddr_i == OFS_CS_PER) ? tim.cs_per :
                  (paddr_i == OFS_STATUS) ? {trig_count[15:0], 13'h0000, state} :
                  32'h0000_0000;

  // Register file; timing writes take effect on the next trigger event only if made while idle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode <= ATST_MODE_SW;
      ss_en <= 1'b0;
      cs_en <= 1'b0;
      tim <= '{acq_dly: RST_ZERO, integ: RST_INTEG, ss_dly: RST_ZERO, ss_wid: RST_ZERO, cs_per: RST_ZERO};
    end else if (apb_wr && state == ATST_IDLE) begin
      if (paddr_i == OFS_CTRL && pstrb_i[0]) begin
        if (pwdata_i[CTRL_MODE_LSB +: 2] != 2'b11) begin
          mode <= atst_mode_type'(pwdata_i[CTRL_MODE_LSB +: 2]);
        end
        ss_en <= pwdata_i[CTRL_SS_EN_BIT];
        cs_en <= pwdata_i[CTRL_CS_EN_BIT];
      end
      if (paddr_i == OFS_ACQ_DLY) tim.acq_dly <= merge(tim.acq_dly, pwdata_i, pstrb_i);
      if (paddr_i == OFS_INTEG) tim.integ <= merge(tim.integ, pwdata_i, pstrb_i);
      if (paddr_i == OFS_SS_DLY) tim.ss_dly <= merge(tim.ss_dly, pwdata_i, pstrb_i);
      if (paddr_i == OFS_SS_WID) tim.ss_wid <= merge(tim.ss_wid, pwdata_i, pstrb_i);
      if (paddr_i == OFS_CS_PER) tim.cs_per <= merge(tim.cs_per, pwdata_i, pstrb_i);
    end
  end

  // APB answer registers; a bad address or a write other than a command to a busy block is flagged.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      prdata_o <= rd_mux;
      pslverr_o <= psel_i && !penable_i &&
                   (!addr_ok || (pwrite_i && state != ATST_IDLE && paddr_i != OFS_CMD));
    end
  end

  // Access to a misaligned or out-of-range address; such an access cannot raise the software trigger.
  wire unused_access = apb_access && !addr_ok;

  // External trigger conditioning.
  atst_sync u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .async_i(ext_trig_i),
    .sync_o(ext_sync)
  );

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_prev <= 1'b0;
      sw_trig <= 1'b0;
    end else begin
      ext_prev <= ext_sync;
      sw_trig <= wr_cmd && !unused_access;
    end
  end

  wire ext_rise = ext_sync && !ext_prev;
  // Only one source is live per mode, and only in idle.
  wire trig_event = (state == ATST_IDLE) &&
                    ((mode == ATST_MODE_SW) ? sw_trig : ext_rise);

  // Microsecond grid restarted at each trigger.
  atst_tick u_tick (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .restart_i(trig_event),
    .tick_o(tick)
  );

  // Phase end conditions.
  wire delay_done = reached(ph_us, tim.acq_dly + INIT_BUSY);
  wire integ_cfg_done = reached(ph_us, tim.integ);
  wire integ_done = (mode == ATST_MODE_LEVEL) ? !ext_sync : (tick && integ_cfg_done);
  wire busy_done = tick && reached(ph_us, FINAL_BUSY);

  // Sequencer: delay, integration, final busy, then transfer.
  always_comb begin
    next_state = state;
    case (state)
      ATST_IDLE: begin
        if (trig_event) next_state = ATST_DELAY;
      end
      ATST_DELAY: begin
        if (tick && delay_done) next_state = ATST_INTEG;
      end
      ATST_INTEG: begin
        if (integ_done) next_state = ATST_BUSY;
      end
      ATST_BUSY: begin
        if (busy_done) next_state = ATST_XFER;
      end
      ATST_XFER: begin
        if (xfer_cnt >= XFER_CYCLES) next_state = ATST_IDLE;
      end
      default: begin
        next_state = ATST_IDLE;
      end
    endcase
  end

  // Counters in microseconds: total since trigger, within phase, within strobe period.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ATST_IDLE;
      cyc_us <= 32'h0000_0000;
      ph_us <= 32'h0000_0000;
      cs_us <= 32'h0000_0000;
      xfer_cnt <= 32'h0000_0000;
      trig_count <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (trig_event) begin
        cyc_us <= 32'h0000_0000;
        trig_count <= trig_count + 32'h0000_0001;
      end else if (tick) begin
        cyc_us <= cyc_us + 32'h0000_0001;
      end
      if (next_state != state) begin
        ph_us <= 32'h0000_0000;
        cs_us <= 32'h0000_0000;
      end else if (tick) begin
        ph_us <= ph_us + 32'h0000_0001;
        cs_us <= (cs_us + 32'h0000_0001 >= tim.cs_per) ? 32'h0000_0000 : cs_us + 32'h0000_0001;
      end
      xfer_cnt <= (state == ATST_XFER) ? xfer_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // Single strobe window measured from the trigger event, ended by integration end.
  wire in_cycle = (state == ATST_DELAY) || (state == ATST_INTEG);
  wire ss_on = ss_en && in_cycle && !ss_done && (tim.ss_wid != 32'h0000_0000) &&
               reached(cyc_us, tim.ss_dly) &&
               !reached(cyc_us, tim.ss_dly + tim.ss_wid);

  // Continuous strobe: high during first half of each period.
  // A period only starts if it can finish by configured integration end, except in level mode.
  wire cs_fits = (mode == ATST_MODE_LEVEL) ||
                 !reached(ph_us - cs_us + tim.cs_per, tim.integ + 32'h0000_0001) ||
                 (ph_us - cs_us + tim.cs_per == tim.integ);
  wire cs_on = cs_en && (state == ATST_INTEG) && (tim.cs_per >= 32'h0000_0002) && cs_fits &&
               (cs_us < (tim.cs_per >> 1));

  // Output registers; leaving integration drops both strobes at once.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      single_strobe_o <= 1'b0;
      cont_strobe_o <= 1'b0;
      busy_o <= 1'b0;
      integrating_o <= 1'b0;
      ss_done <= 1'b0;
    end else begin
      single_strobe_o <= ss_on && (next_state == ATST_DELAY || next_state == ATST_INTEG);
      cont_strobe_o <= cs_on && (next_state == ATST_INTEG);
      busy_o <= (next_state != ATST_IDLE);
      integrating_o <= (next_state == ATST_INTEG);
      if (trig_event) ss_done <= 1'b0;
      else if (single_strobe_o && !ss_on) ss_done <= 1'b1;
    end
  end

endmodule

// ### atst_monitor.sv
// Checker of strobe, phase and bus timing at the sequencer's ports.
`timescale 1ns/1ps
module atst_monitor (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic single_strobe_o,
  input wire logic cont_strobe_o,
  input wire logic busy_o,
  input wire logic integrating_o
);
  // One clock domain, so all checks rest while reset is high.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Steps of a bus answer and of the tail of a cycle.
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence answer_s; pready_o ##1 !pready_o; endsequence
  sequence tail_s; busy_o[*8] ##1 !single_strobe_o; endsequence
  ss_in_cycle_a: assert property (single_strobe_o |-> busy_o) else $error("single strobe outside a cycle");
  cs_in_integ_a: assert property (cont_strobe_o |-> integrating_o) else $error("cont strobe outside integ");
  cs_half_a: assert property ($rose(cont_strobe_o) |-> (cont_strobe_o || !integrating_o)[*8])
    else $error("cont strobe high half too short");
  integ_busy_a: assert property (integrating_o |-> busy_o) else $error("integration while not busy");
  delay_first_a: assert property ($rose(integrating_o) |-> $past(busy_o, 8))
    else $error("integration began without delay phase");
  final_busy_a: assert property ($fell(integrating_o) |-> tail_s) else $error("final busy or strobe cut wrong");
  ready_next_a: assert property (setup_s |=> answer_s) else $error("bus answer not in access cycle");
  err_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
endmodule

bind atst_top atst_monitor mon (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .single_strobe_o(single_strobe_o),
  .cont_strobe_o(cont_strobe_o), .busy_o(busy_o), .integrating_o(integrating_o));

// ### atst_trig_src.sv
// External trigger source that pulses the trigger line for a set number of cycles.
`timescale 1ns/1ps
module atst_trig_src (
  input wire logic clk_i,
  output logic trig_o
);
  // The line idles low, so no stray edge starts a cycle.
  initial trig_o = 1'b0;
  // The rising edge starts a cycle; in level mode the high time sets integration.
  task automatic pulse(input int n);
    @(posedge clk_i);
    trig_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    trig_o <= 1'b0;
  endtask
endmodule

// ### acquisition_trigger_strobe_timing_tb.sv
// Self-checking bench for the acquisition trigger sequencer.
`timescale 1ns/1ps
module acquisition_trigger_strobe_timing_tb
  import atst_pkg::*;
;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, ext_trig_i, single_strobe_o, cont_strobe_o, busy_o, integrating_o;
  logic [31:0] rq;
  logic re;
  logic cs_q = 1'b0;
  int n_fail = 0;
  int n_tests = 0;
  int n_ss = 0, n_cs = 0, n_int = 0, n_pre = 0, n_csr = 0;

  always #50 clk_i = ~clk_i;

  // Short busy times keep every cycle under a thousand clocks.
  atst_top #(.INIT_BUSY(32'h2), .FINAL_BUSY(32'h2)) uut (
    .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ext_trig_i(ext_trig_i), .single_strobe_o(single_strobe_o),
    .cont_strobe_o(cont_strobe_o), .busy_o(busy_o), .integrating_o(integrating_o));
  atst_trig_src src (.clk_i(clk_i), .trig_o(ext_trig_i));

  // Cycle counts of each output while a cycle runs; edges allow one tick of grid error.
  always @(posedge clk_i) begin
    if (busy_o === 1'b1) begin
      n_ss += single_strobe_o;
      n_cs += cont_strobe_o;
      n_pre += (n_int == 0) && !integrating_o;
      n_int += integrating_o;
      n_csr += cont_strobe_o && !cs_q;
    end
    cs_q = cont_strobe_o;
  end

  // One bus transfer; the request holds until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    rq = prdata_o;
    re = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic check_eq(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %0h seen %0h", s, e, g);
    end
  endtask

  task automatic check_near(input string s, input int e, input int g, input int t);
    n_tests++;
    if (g < e - t || g > e + t) begin
      n_fail++;
      $display("unexpected %s expected %0d seen %0d", s, e, g);
    end
  endtask

  task automatic cfg(input logic [31:0] c, a, i, sd, sw, p);
    apb(1'b1, OFS_CTRL, c);
    apb(1'b1, OFS_ACQ_DLY, a);
    apb(1'b1, OFS_INTEG, i);
    apb(1'b1, OFS_SS_DLY, sd);
    apb(1'b1, OFS_SS_WID, sw);
    apb(1'b1, OFS_CS_PER, p);
  endtask

  // A hold of zero triggers by command, otherwise by an external pulse.
  task automatic run(input int hold);
    int k;
    n_ss = 0;
    n_cs = 0;
    n_int = 0;
    n_pre = 0;
    n_csr = 0;
    if (hold == 0) apb(1'b1, OFS_CMD, 32'h1);
    else src.pulse(hold);
    k = 0;
    while (busy_o !== 1'b1 && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    k = 0;
    while (busy_o !== 1'b0 && k < 5000) begin
      @(posedge clk_i);
      k++;
    end
    check_eq("cycle end", 32'h0, {31'h0, busy_o});
  endtask

  task automatic t_reset();
    apb(1'b0, OFS_CTRL, 32'h0);
    check_eq("mode", 32'h0, rq & 32'h3);
    apb(1'b0, OFS_INTEG, 32'h0);
    check_eq("integ", RST_INTEG, rq);
    apb(1'b0, 8'h20, 32'h0);
    check_eq("bad addr", 32'h1, {31'h0, re});
    $display("test reset done");
  endtask

  task automatic t_sw();
    cfg(32'hc, 32'h3, 32'h14, 32'h1, 32'h4, 32'h6);
    run(0);
    check_near("pre", 55, n_pre, 12);
    check_near("integ", 200, n_int, 10);
    check_near("ss high", 40, n_ss, 10);
    check_near("cs periods", 3, n_csr, 0);
    check_near("cs high", 90, n_cs, 10);
    $display("test software done");
  endtask

  // A long single strobe is cut; a command in mid-cycle must not start another.
  task automatic t_cut();
    cfg(32'h4, 32'h3, 32'h14, 32'h6, 32'h64, 32'h6);
    fork
      run(0);
      begin
        repeat (150) @(posedge clk_i);
        apb(1'b1, OFS_CMD, 32'h1);
      end
    join
    check_near("ss cut", 195, n_ss, 15);
    check_near("cs off", 0, n_cs, 0);
    repeat (60) @(posedge clk_i);
    check_eq("no retrigger", 32'h0, {31'h0, busy_o});
    $display("test cut done");
  endtask

  task automatic t_ext();
    cfg(32'h9, 32'h3, 32'h14, 32'h1, 32'h4, 32'h8);
    run(5);
    check_near("edge integ", 200, n_int, 10);
    check_near("edge periods", 2, n_csr, 0);
    check_near("ss off", 0, n_ss, 0);
    cfg(32'ha, 32'h0, 32'h14, 32'h1, 32'h4, 32'h4);
    run(220);
    check_near("level integ", 194, n_int, 15);
    check_near("level periods", 5, n_csr, 0);
    $display("test external done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence after twenty cycles of reset.
  initial begin
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_sw();
    t_cut();
    t_ext();
    print_verdict();
  end

  // Watchdog: the tests need under two thousand cycles.
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    print_verdict();
  end
endmodule
